// ### logic/rhi_defines.vh
// Overview of operation
// - With FIFO enabled, FIFO level pin goes low once fill reaches limit.
// - The same pin shifts the status word out during a serial frame.
// - Event request asserts on wake-up, low battery, FIFO fill or overflow whose bit is set in the mask register.
// - Status word top four bits name the pending event sources.
// - FIFO unused: received data bit is driven out on the data pin.
// - FIFO used: data pin becomes active-low FIFO read select input.
// - FIFO unused: recovered bit clock is driven on the clock pin.
// - FIFO used: clock pin is high while unread bits remain.
// - Host clock output frequency is chosen by the clock output register.
`ifndef RHI_DEFINES_VH
`define RHI_DEFINES_VH

// APB byte offsets
`define RHI_OFS_CONFIG   8'h00
`define RHI_OFS_FIFO_CFG 8'h04
`define RHI_OFS_CLK_CFG  8'h08
`define RHI_OFS_STATUS   8'h0c
`define RHI_OFS_MASK     8'h10
`define RHI_OFS_LAST_CMD 8'h14

// Reset values
`define RHI_RST_CONFIG   16'h893a
`define RHI_RST_FIFO_CFG 16'hce89
`define RHI_RST_CLK_CFG  16'hc200

// Serial command codes (upper byte of a frame)
`define RHI_CMD_CONFIG   8'h89
`define RHI_CMD_FIFO_CFG 8'hce
`define RHI_CMD_CLK_CFG  8'hc2

// Field positions
`define RHI_CFG_FIFO_EN  6
`define RHI_FCFG_LIM_HI  7
`define RHI_FCFG_LIM_LO  4
`define RHI_CLK_SEL_HI   7
`define RHI_CLK_SEL_LO   5

// Status bits
`define RHI_ST_WAKEUP    0
`define RHI_ST_LOWBAT    1
`define RHI_ST_FILL      2
`define RHI_ST_OVERFLOW  3

// Frame and FIFO sizes
`define RHI_FRAME_LAST   4'hf
`define RHI_FIFO_DEPTH   16

`endif

// ### logic/rhi_sync.v
`timescale 1ns/1ps
module rhi_sync #(
    parameter W = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Data
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                end else if (ce) begin
                    meta_q[i] <= async_i[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
    assign sync_o = sync_q;
endmodule

// ### logic/rhi_top.v
`timescale 1ns/1ps
`include "rhi_defines.vh"
module rhi_top (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    // Serial port pins
    input wire sck,
    input wire sdi,
    input wire port_select_n,
    output reg sdo_pin,
    // Data pin, two-way
    input wire data_pin_i,
    output reg data_pin_o,
    output reg data_pin_oe_n,
    // Other pins
    output reg clock_flag_pin,
    output reg event_request_n,
    output reg host_clock_output,
    // Receiver side, same clock
    input wire rx_bit,
    input wire rx_bit_strobe,
    input wire wakeup_timeout,
    input wire low_battery
);
    wire [3:0] pins_s;
    wire sck_s;
    wire sdi_s;
    wire cs_n_s;
    wire fsel_n_s;
    reg sck_prev_q;
    reg [15:0] config_q;
    reg [15:0] fifo_cfg_q;
    reg [15:0] clk_cfg_q;
    reg [3:0] stat_q;
    reg [3:0] mask_q;
    reg [15:0] last_cmd_q;
    reg [15:0] shift_in_q;
    reg [15:0] shift_out_q;
    reg [3:0] bit_cnt_q;
    reg [`RHI_FIFO_DEPTH-1:0] fifo_mem_q;
    reg [3:0] wr_ptr_q;
    reg [3:0] rd_ptr_q;
    reg [4:0] fill_q;
    reg [7:0] div_cnt_q;
    wire sck_rise;
    wire sck_fall;
    wire fifo_en;
    wire [3:0] fill_lim;
    wire [2:0] clk_sel;
    wire frame_done;
    wire [15:0] frame_word;
    wire push;
    wire pop;
    wire ovf_ev;
    wire fill_ev;
    wire [4:0] fill_d;
    wire [15:0] status_word;
    wire apb_wr;
    wire apb_rd_go;
    wire [3:0] ev_set;
    wire [3:0] w1c;
    wire [7:0] half_period;

    rhi_sync #(
        .W(4)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_i({data_pin_i, port_select_n, sdi, sck}),
        .sync_o(pins_s)
    );
    assign sck_s = pins_s[0];
    assign sdi_s = pins_s[1];
    assign cs_n_s = pins_s[2];
    assign fsel_n_s = pins_s[3];

    assign fifo_en = config_q[`RHI_CFG_FIFO_EN];
    assign fill_lim = fifo_cfg_q[`RHI_FCFG_LIM_HI:`RHI_FCFG_LIM_LO];
    assign clk_sel = clk_cfg_q[`RHI_CLK_SEL_HI:`RHI_CLK_SEL_LO];

    // Edges found by sampling the link clock with pclk
    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;

    // Frame ends on the 16th rising edge while select stays low
    assign frame_done = ~cs_n_s & sck_rise & (bit_cnt_q == `RHI_FRAME_LAST);
    assign frame_word = {shift_in_q[14:0], sdi_s};

    // FIFO traffic
    assign push = fifo_en & rx_bit_strobe;
    assign pop = fifo_en & ~fsel_n_s & cs_n_s & sck_rise & (fill_q != 5'h00);
    assign ovf_ev = push & ~pop & (fill_q == 5'h10);
    assign fill_d = (push & ~ovf_ev & ~pop) ? fill_q + 5'h01 :
                    (pop & ~push) ? fill_q - 5'h01 : fill_q;
    // A limit of one turns the level flag into a not-empty flag
    assign fill_ev = fifo_en & (fill_lim != 4'h0) &
                     (fill_d >= {1'b0, fill_lim}) & (fill_q < {1'b0, fill_lim});

    // Event sources in the top four status bits
    assign status_word = {stat_q, (fill_q != 5'h00), 6'h00, fill_q};
    assign ev_set = {ovf_ev, fill_ev, low_battery, wakeup_timeout};

    // APB: one wait state, then the transfer completes
    assign apb_wr = psel & penable & pready & pwrite;
    assign apb_rd_go = psel & penable & ~pready;
    assign w1c = (apb_wr && paddr == `RHI_OFS_STATUS) ? pwdata[3:0] : 4'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_q <= 1'b1;
        end else if (ce) begin
            sck_prev_q <= sck_s;
        end
    end

    // Serial shift registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_in_q <= 16'h0000;
            shift_out_q <= 16'h0000;
            bit_cnt_q <= 4'h0;
            sdo_pin <= 1'b1;
        end else if (ce) begin
            if (cs_n_s) begin
                bit_cnt_q <= 4'h0;
                shift_out_q <= status_word;
                if (fifo_en && !fsel_n_s) begin
                    sdo_pin <= fifo_mem_q[rd_ptr_q];
                end else begin
                    // Level pin low once the fill limit is met
                    sdo_pin <= ~(fifo_en & (fill_lim != 4'h0) &
                                 (fill_q >= {1'b0, fill_lim}));
                end
            end else begin
                if (sck_rise) begin
                    shift_in_q <= frame_word;
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                // Status leaves MSB first, changing on the falling edge
                if (sck_fall) begin
                    sdo_pin <= shift_out_q[14];
                    shift_out_q <= {shift_out_q[14:0], 1'b0};
                end else if (bit_cnt_q == 4'h0) begin
                    // Status is frozen at select, so the first bit stands before any edge
                    sdo_pin <= shift_out_q[15];
                end
            end
        end
    end

    // Configuration: serial frames and APB writes share one process
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_q <= `RHI_RST_CONFIG;
            fifo_cfg_q <= `RHI_RST_FIFO_CFG;
            clk_cfg_q <= `RHI_RST_CLK_CFG;
            mask_q <= 4'h0;
            last_cmd_q <= 16'h0000;
        end else if (ce) begin
            if (frame_done) begin
                last_cmd_q <= frame_word;
                case (frame_word[15:8])
                    `RHI_CMD_CONFIG: config_q[7:0] <= frame_word[7:0];
                    `RHI_CMD_FIFO_CFG: fifo_cfg_q[7:0] <= frame_word[7:0];
                    `RHI_CMD_CLK_CFG: clk_cfg_q[7:0] <= frame_word[7:0];
                    default: last_cmd_q <= frame_word;
                endcase
            end
            // APB wins when both land in one cycle
            if (apb_wr) begin
                case (paddr)
                    `RHI_OFS_CONFIG: config_q[7:0] <= pwdata[7:0];
                    `RHI_OFS_FIFO_CFG: fifo_cfg_q[7:0] <= pwdata[7:0];
                    `RHI_OFS_CLK_CFG: clk_cfg_q[7:0] <= pwdata[7:0];
                    `RHI_OFS_MASK: mask_q <= pwdata[3:0];
                    default: mask_q <= mask_q;
                endcase
            end
        end
    end

    // Sticky status; a new event beats a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 4'h0;
            event_request_n <= 1'b1;
            irq <= 1'b0;
        end else if (ce) begin
            stat_q <= (stat_q & ~w1c) | ev_set;
            event_request_n <= ~|(((stat_q & ~w1c) | ev_set) & mask_q);
            irq <= |(((stat_q & ~w1c) | ev_set) & mask_q);
        end
    end

    // FIFO storage, one flip-flop per entry
    genvar i;
    generate
        for (i = 0; i < `RHI_FIFO_DEPTH; i = i + 1) begin : g_fifo
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fifo_mem_q[i] <= 1'b0;
                end else if (ce && push && !ovf_ev && wr_ptr_q == i) begin
                    fifo_mem_q[i] <= rx_bit;
                end
            end
        end
    endgenerate

    // Overflowing bits are dropped; the oldest data is kept
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            fill_q <= 5'h00;
        end else if (ce) begin
            if (!fifo_en) begin
                wr_ptr_q <= 4'h0;
                rd_ptr_q <= 4'h0;
                fill_q <= 5'h00;
            end else begin
                if (push && !ovf_ev) begin
                    wr_ptr_q <= wr_ptr_q + 4'h1;
                end
                if (pop) begin
                    rd_ptr_q <= rd_ptr_q + 4'h1;
                end
                fill_q <= fill_d;
            end
        end
    end

    // Data and clock pins change role with the FIFO enable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_pin_o <= 1'b0;
            data_pin_oe_n <= 1'b0;
            clock_flag_pin <= 1'b0;
        end else if (ce) begin
            if (fifo_en) begin
                data_pin_o <= 1'b0;
                data_pin_oe_n <= 1'b1;
                clock_flag_pin <= (fill_d != 5'h00);
            end else begin
                data_pin_oe_n <= 1'b0;
                if (rx_bit_strobe) begin
                    data_pin_o <= rx_bit;
                end
                clock_flag_pin <= rx_bit_strobe;
            end
        end
    end

    // Host clock: half period of 2^sel pclk cycles
    assign half_period = 8'h01 << clk_sel;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 8'h00;
            host_clock_output <= 1'b0;
        end else if (ce) begin
            if (div_cnt_q >= half_period - 8'h01) begin
                div_cnt_q <= 8'h00;
                host_clock_output <= ~host_clock_output;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end

    // APB answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= apb_rd_go;
            if (apb_rd_go) begin
                pslverr <= 1'b0;
                case (paddr)
                    `RHI_OFS_CONFIG: prdata <= {16'h0000, config_q};
                    `RHI_OFS_FIFO_CFG: prdata <= {16'h0000, fifo_cfg_q};
                    `RHI_OFS_CLK_CFG: prdata <= {16'h0000, clk_cfg_q};
                    `RHI_OFS_STATUS: prdata <= {16'h0000, status_word};
                    `RHI_OFS_MASK: prdata <= {28'h0000000, mask_q};
                    `RHI_OFS_LAST_CMD: prdata <= {16'h0000, last_cmd_q};
                    default: begin
                        prdata <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end else begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule

// ### test/rhi_asserts.sv
`timescale 1ns/1ps
module rhi_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Bus side
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire irq,
    // Pins
    input wire port_select_n,
    input wire sdo_pin,
    input wire data_pin_o,
    input wire data_pin_oe_n,
    input wire clock_flag_pin,
    input wire event_request_n,
    input wire host_clock_output,
    input wire rx_bit,
    input wire rx_bit_strobe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ONE_WAIT: assert property (psel && penable && !pready && ce |=> pready)
        else $error("bus access not answered after one wait");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && penable) ##1 !pready)
        else $error("answer without a request or longer than one cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data or no ready");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    AST_IRQ_PAIR: assert property (irq != event_request_n)
        else $error("event request pin disagrees with interrupt");
    AST_DATA_BIT: assert property (!data_pin_oe_n && rx_bit_strobe |=> data_pin_o == $past(rx_bit))
        else $error("received bit not on data pin");
    AST_BIT_CLOCK: assert property (!data_pin_oe_n && rx_bit_strobe && ce |=> clock_flag_pin)
        else $error("recovered clock missing");
    AST_SDO_IDLE: assert property ((port_select_n && !data_pin_oe_n)[*6] |-> sdo_pin)
        else $error("level flag low with FIFO off");
    AST_CLK_RUNS: assert property (1 |-> ##[1:260] $changed(host_clock_output))
        else $error("host clock stuck");
endmodule

bind rhi_top rhi_checker u_chk (.pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
    .prdata, .irq, .port_select_n, .sdo_pin, .data_pin_o, .data_pin_oe_n, .clock_flag_pin,
    .event_request_n, .host_clock_output, .rx_bit, .rx_bit_strobe);

// ### test/rhi_host_model.sv
`timescale 1ns/1ps
module rhi_host_model (
    // Serial pins
    output logic sck,
    output logic sdi,
    output logic port_select_n,
    output logic fifo_read_select_n,
    // Answer
    input wire sdo_pin
);
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        port_select_n = 1'b1;
        fifo_read_select_n = 1'b1;
    end
    // Link clock rests low between frames; sdi flips after use so stale data is never reused
    task automatic xfer(input logic fifo, input logic [15:0] w, input int n,
                        output logic [15:0] st);
        st = 16'h0;
        // Keep pin changes off the pclk sampling edge
        #1;
        if (fifo)
            fifo_read_select_n = 1'b0;
        else
            port_select_n = 1'b0;
        #32;
        for (int i = 0; i < n; i++) begin
            sdi = w[15-i];
            #16;
            if (fifo)
                st[15-i] = sdo_pin;
            sck = 1'b1;
            #16;
            if (!fifo)
                st[15-i] = sdo_pin;
            sck = 1'b0;
        end
        #16;
        port_select_n = 1'b1;
        fifo_read_select_n = 1'b1;
        sdi = ~sdi;
        #32;
    endtask
endmodule

// ### test/rhi_top_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module rhi_top_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic rx_bit = 1'b0, rx_bit_strobe = 1'b0, wakeup_timeout = 1'b0, low_battery = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, sck, sdi, port_select_n, sdo_pin, host_sel_n, data_pin_o;
    wire data_pin_oe_n, clock_flag_pin, event_request_n, host_clock_output;
    // Two-way data pin resolved from the DUT output enable alone
    wire data_wire = data_pin_oe_n ? host_sel_n : data_pin_o;
    int miscompares = 0, cmp_count = 0, seed = 32'hbec5f8ed, n;
    logic [33:0] exp_q[$];
    logic [33:0] note;
    logic [16:0] bits = 17'h0;
    logic [15:0] st;

    rhi_top u_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .sck, .sdi, .port_select_n, .sdo_pin,
        .data_pin_i(data_wire), .data_pin_o, .data_pin_oe_n, .clock_flag_pin,
        .event_request_n, .host_clock_output, .rx_bit, .rx_bit_strobe, .wakeup_timeout,
        .low_battery);
    rhi_host_model u_host (.sck, .sdi, .port_select_n, .fifo_read_select_n(host_sel_n),
        .sdo_pin);

    initial begin
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (pready === 1'b1 && exp_q.size() == 0) begin
            miscompares++;
            $display("[FAIL] pready exp 0 got 1");
        end else if (pready === 1'b1) begin
            note = exp_q.pop_front();
            `CHK("pslverr", note[32], pslverr)
            if (note[33])
                `CHK("prdata", note[31:0], prdata)
        end
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic err);
        int k;
        exp_q.push_back({!w, err, ex});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            conclude();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic pulse(input logic wk);
        @(posedge pclk);
        if (wk)
            wakeup_timeout <= 1'b1;
        else
            low_battery <= 1'b1;
        @(posedge pclk);
        wakeup_timeout <= 1'b0;
        low_battery <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic push;
        logic [31:0] r;
        r = $random(seed);
        @(posedge pclk);
        rx_bit <= r[0];
        rx_bit_strobe <= 1'b1;
        bits = {bits[15:0], r[0]};
        @(posedge pclk);
        rx_bit_strobe <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic half(output int c);
        logic v;
        @(posedge pclk);
        for (int j = 0; j < 2; j++) begin
            v = host_clock_output;
            c = 0;
            while (host_clock_output === v && c < 300) begin
                @(posedge pclk);
                c++;
            end
        end
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, 32'h893a, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 32'hce89, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h10, 32'h1, 32'h0, 1'b0);
        pulse(1'b0);
        `CHK("irq masked", 1'b0, irq)
        pulse(1'b1);
        `CHK("event_request_n", 1'b0, event_request_n)
        apb(1'b0, 8'h0c, 32'h0, 32'h3000, 1'b0);
        apb(1'b1, 8'h0c, 32'h1, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        u_host.xfer(1'b0, 16'h0000, 16, st);
        `CHK("sdo status", 16'h2000, st)
        apb(1'b1, 8'h0c, 32'h2, 32'h0, 1'b0);
        repeat (4) begin
            push();
            `CHK("data_pin_o", bits[0], data_pin_o)
        end
        u_host.xfer(1'b0, 16'hce19, 16, st);
        u_host.xfer(1'b0, 16'h897a, 16, st);
        apb(1'b0, 8'h04, 32'h0, 32'hce19, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h897a, 1'b0);
        `CHK("data_pin_oe_n", 1'b1, data_pin_oe_n)
        `CHK("sdo level idle", 1'b1, sdo_pin)
        repeat (3) push();
        `CHK("not empty", 1'b1, clock_flag_pin)
        `CHK("sdo level", 1'b0, sdo_pin)
        apb(1'b0, 8'h0c, 32'h0, 32'h4803, 1'b0);
        u_host.xfer(1'b1, 16'h0, 3, st);
        `CHK("fifo bits", bits[2:0], st[15:13])
        `CHK("empty", 1'b0, clock_flag_pin)
        apb(1'b1, 8'h0c, 32'h4, 32'h0, 1'b0);
        repeat (17) push();
        apb(1'b0, 8'h0c, 32'h0, 32'hc810, 1'b0);
        u_host.xfer(1'b1, 16'h0, 16, st);
        `CHK("fifo word", bits[16:1], st)
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 8'h08, 32'hc200 | (s << 5), 32'h0, 1'b0);
            half(n);
            `CHK("half period", 1 << s, n)
        end
        conclude();
    end
endmodule
